// >>> rtl/dsp_vector_shift_right_unit.sv
`timescale 1ns/1ps
`default_nettype none
// Function
// - Decode packed-byte arithmetic shift, plain and rounding
// - Decode register-amount rounding word shift
// - Decode immediate rounding word shift, amount bits 25:21
// - Decode halfword logical shift, bit25 zero
// - Byte shifts use amount bits 2:0
// - Rounding byte: nine-bit add, keep bits 8:1
// - Zero-amount rounding byte passes unchanged
// - Byte result sign fills upper 32 bits
// - Register word shift uses amount bits 4:0
// - Rounded word result sign-extended to 64
// - Halfword logical shift zero-fills, amount 0-15
// - Upper halfword bit 15 fills upper 32
// - No operand-dependent exceptions raised
module dsp_vector_shift_right_unit
  import vshift_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_issue,
  input  wire logic [31:0] i_instr,
  input  wire logic [63:0] i_amount_source_reg,
  input  wire logic [63:0] i_value_source_reg,
  output logic             o_valid,
  output logic             o_hit,
  output logic      [4:0]  o_dest_idx,
  output logic      [63:0] o_result
);
  // ==========================================================
  // Shift helpers
  // ==========================================================
  // Rounding arithmetic byte shift; zero amount appends a zero only
  function automatic logic [7:0] rnd_byte(input logic [7:0] a,
                                          input logic [2:0] s);
    logic [8:0] t;
    t = {a, 1'b0};
    if (s != 3'h0)
    begin
      t = 9'($signed({a, 1'b0}) >>> s) + 9'h001;
    end
    rnd_byte = t[8:1];
  endfunction

  // Rounding arithmetic word shift over a 33-bit intermediate
  function automatic logic [31:0] rnd_word(input logic [31:0] a,
                                           input logic [4:0] s);
    logic [32:0] t;
    t = {a, 1'b0};
    if (s != 5'h00)
    begin
      t = 33'($signed({a, 1'b0}) >>> s) + 33'h1;
    end
    rnd_word = t[32:1];
  endfunction

  // ==========================================================
  // Decode and compute
  // ==========================================================
  typedef struct packed {
    logic        valid;
    logic        hit;
    logic [4:0]  dest;
    logic [63:0] res;
  } state_t;

  state_t     st_q;
  state_t     st_d;
  logic [2:0] op;
  logic [4:0] imm_amt;
  logic [31:0] v;
  logic [31:0] r32;
  logic [2:0] bamt;
  logic [15:0] hp_hi;
  logic [15:0] hp_lo;

  vshift_decode u_dec (
    .i_instr   (i_instr),
    .o_op      (op),
    .o_imm_amt (imm_amt)
  );

  assign v    = i_value_source_reg[31:0];
  assign bamt = i_amount_source_reg[2:0];

  // Next result; purely combinational from operands, no traps
  always_comb
  begin
    st_d = '0;
    r32  = '0;
    hp_hi = v[31:16] >> imm_amt[3:0];
    hp_lo = v[15:0] >> imm_amt[3:0];
    case (shift_op_t'(op))
      OP_BQ_VAR:
      begin
        for (int i = 0; i < 4; i++)
          r32[8*i +: 8] = 8'($signed(v[8*i +: 8]) >>> bamt);
      end
      OP_BQ_RND:
      begin
        for (int i = 0; i < 4; i++)
          r32[8*i +: 8] = rnd_byte(v[8*i +: 8], bamt);
      end
      OP_W_VAR: r32 = rnd_word(v, i_amount_source_reg[4:0]);
      OP_W_IMM: r32 = rnd_word(v, imm_amt);
      OP_HP_LOG: r32 = {hp_hi, hp_lo};
      default:  r32 = '0;
    endcase
    // All five results sign-extend from bit 31 of the 32-bit result;
    // idle cycles give zero so stale operands never reach writeback
    if (i_issue)
    begin
      st_d.res = {{32{r32[31]}}, r32};
    end
    st_d.hit   = i_issue && (op != OP_NONE);
    st_d.valid = i_issue;
    st_d.dest  = i_instr[DST_HI:DST_LO];
  end

  // Result register presents to writeback one cycle later
  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_valid    = st_q.valid;
  assign o_hit      = st_q.hit;  // no other exception output
  assign o_dest_idx = st_q.dest;
  assign o_result   = st_q.res;

  // ==========================================================
  // Reference arithmetic for the checks
  // ==========================================================
  // Round half up as add-then-shift; built apart from rnd_byte so that
  // a slip in one formulation shows up against the other
  function automatic logic [7:0] ref_rnd8(input logic [7:0] a,
                                          input logic [2:0] s);
    logic signed [8:0] t;
    t = $signed({a[7], a});
    if (s != 3'h0)
    begin
      t = (t + (9'sh001 <<< (s - 3'h1))) >>> s;
    end
    ref_rnd8 = t[7:0];
  endfunction

  // Same add-then-shift rounding over a signed word
  function automatic logic [31:0] ref_rnd32(input logic [31:0] a,
                                            input logic [4:0] s);
    logic signed [32:0] t;
    t = $signed({a[31], a});
    if (s != 5'h00)
    begin
      t = (t + (33'sh000000001 <<< (s - 5'h01))) >>> s;
    end
    ref_rnd32 = t[31:0];
  endfunction

  // ==========================================================
  // Assertions
  // ==========================================================
  sequence s_issue_word_zero;
    i_issue && op == OP_W_IMM && imm_amt == 5'h00;
  endsequence

  a_issue_latency: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_issue |=> o_valid)
    else $error("result not valid one cycle after issue");
  a_dest_carry: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_issue |=> o_dest_idx == $past(i_instr[15:11]))
    else $error("destination index wrong");
  a_sign_upper: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_hit |-> o_result[63:32] == {32{o_result[31]}})
    else $error("upper half not sign fill");
  a_word_zero_pass: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_issue_word_zero |=> o_result[31:0] == $past(v))
    else $error("zero-amount word changed");
  a_byte_rnd_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_issue && op == OP_BQ_RND && bamt == 3'h0
      |=> o_result[31:0] == $past(v))
    else $error("zero-amount rounding bytes changed");
  a_byte_plain: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_issue && op == OP_BQ_VAR |=> o_result[7:0] ==
      8'($signed($past(v[7:0])) >>> $past(bamt)))
    else $error("low byte shift wrong");
  a_half_logic: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_issue && op == OP_HP_LOG |=> o_result[31:16] ==
      ($past(v[31:16]) >> $past(imm_amt[3:0])))
    else $error("upper halfword shift wrong");
  a_decode_half: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_instr[25] && i_instr[10:6] == SUB_HP_IMM_LOG |-> op != OP_HP_LOG)
    else $error("halfword shift decoded with bit 25 set");
  a_word_round: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_issue && op == OP_W_VAR && i_amount_source_reg[4:0] == 5'h01
      |=> o_result[31:0] == 32'(($signed({$past(v[31]), $past(v)})
      + 33'sh1) >>> 1))
    else $error("word round by one wrong");

  // Multi-step checks: issue of one form, then its lane result next cycle
  sequence s_byte_rnd_issue;
    i_issue && op == OP_BQ_RND;
  endsequence

  sequence s_word_imm_issue;
    i_issue && op == OP_W_IMM;
  endsequence

  sequence s_half_issue;
    i_issue && op == OP_HP_LOG;
  endsequence

  a_byte_rnd_low: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_byte_rnd_issue |=> o_result[7:0] ==
      ref_rnd8($past(v[7:0]), $past(bamt)))
    else $error("rounded low byte wrong");
  a_byte_rnd_high: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_byte_rnd_issue |=> o_result[31:24] ==
      ref_rnd8($past(v[31:24]), $past(bamt)))
    else $error("rounded high byte wrong");
  a_word_imm_rnd: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_word_imm_issue |=> o_result[31:0] ==
      ref_rnd32($past(v), $past(imm_amt)))
    else $error("immediate word rounding wrong");
  a_half_low: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    s_half_issue |=> o_result[15:0] ==
      ($past(v[15:0]) >> $past(imm_amt[3:0])))
    else $error("lower halfword shift wrong");
  // An idle cycle must never hand writeback a result
  a_idle_quiet: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !i_issue |=> !o_valid)
    else $error("result valid without issue");
  // Refused or idle slots carry zero, never a stale value
  a_miss_zero: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    !o_hit |-> o_result == 64'h0)
    else $error("result nonzero without hit");
endmodule // dsp_vector_shift_right_unit
`default_nettype wire

// >>> inc/vshift_pkg.sv
`default_nettype none
package vshift_pkg;
  // ==========================================================
  // Instruction fields
  // ==========================================================
  localparam logic [5:0] EXT_MAJOR_OPCODE = 6'h1f;  // 011111
  localparam logic [5:0] SHIFT_GROUP_FUNC = 6'h13;  // 010011
  localparam logic [4:0] SUB_BQ_VAR       = 5'h06;  // 00110
  localparam logic [4:0] SUB_BQ_VAR_RND   = 5'h07;  // 00111
  localparam logic [4:0] SUB_W_VAR_RND    = 5'h17;  // 10111
  localparam logic [4:0] SUB_W_IMM_RND    = 5'h15;  // 10101
  localparam logic [4:0] SUB_HP_IMM_LOG   = 5'h19;  // 11001
  localparam int MAJOR_HI = 31;
  localparam int MAJOR_LO = 26;
  localparam int AMT_HI   = 25;
  localparam int AMT_LO   = 21;
  localparam int VAL_HI   = 20;
  localparam int VAL_LO   = 16;
  localparam int DST_HI   = 15;
  localparam int DST_LO   = 11;
  localparam int SUB_HI   = 10;
  localparam int SUB_LO   = 6;
  localparam int FUNC_HI  = 5;
  localparam int FUNC_LO  = 0;
  localparam int EXEC_LATENCY = 1;  // Cycles from issue to result

  // Operation selector
  typedef enum logic [2:0] {
    OP_NONE     = 3'b000,
    OP_BQ_VAR   = 3'b001,
    OP_BQ_RND   = 3'b010,
    OP_W_VAR    = 3'b011,
    OP_W_IMM    = 3'b100,
    OP_HP_LOG   = 3'b101
  } shift_op_t;
endpackage
`default_nettype wire

// >>> rtl/vshift_decode.sv
`timescale 1ns/1ps
`default_nettype none
module vshift_decode
  import vshift_pkg::*;
(
  input  wire logic [31:0] i_instr,
  output logic      [2:0]  o_op,
  output logic      [4:0]  o_imm_amt
);
  // ==========================================================
  // Field decode
  // ==========================================================
  logic grp;
  assign grp = (i_instr[MAJOR_HI:MAJOR_LO] == EXT_MAJOR_OPCODE) &&
               (i_instr[FUNC_HI:FUNC_LO] == SHIFT_GROUP_FUNC);
  assign o_imm_amt = i_instr[AMT_HI:AMT_LO];

  // Sub-operation selects one of the five shifts
  always_comb
  begin
    o_op = OP_NONE;
    if (grp)
    begin
      case (i_instr[SUB_HI:SUB_LO])
        SUB_BQ_VAR:     o_op = OP_BQ_VAR;
        SUB_BQ_VAR_RND: o_op = OP_BQ_RND;
        SUB_W_VAR_RND:  o_op = OP_W_VAR;
        SUB_W_IMM_RND:  o_op = OP_W_IMM;
        SUB_HP_IMM_LOG:
          if (!i_instr[AMT_HI]) o_op = OP_HP_LOG;
        default:        o_op = OP_NONE;
      endcase
    end
  end
endmodule // vshift_decode
`default_nettype wire

// >>> bench/wb_regfile.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Writeback side: register file that takes each hit result
// ==========================================================
module wb_regfile
(
  input  wire logic        i_mclk,
  input  wire logic        i_we,
  input  wire logic [4:0]  i_wr_idx,
  input  wire logic [63:0] i_wr_data,
  input  wire logic [4:0]  i_rd_idx,
  output logic      [63:0] o_rd_data
);
  logic [63:0] regs [32];
  // No reset on purpose: unwritten entries stay unknown
  always_ff @(posedge i_mclk)
  begin
    if (i_we)
      regs[i_wr_idx] <= i_wr_data;
  end
  assign o_rd_data = regs[i_rd_idx];
endmodule // wb_regfile
`default_nettype wire

// >>> bench/tb_dsp_vector_shift_right_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_vector_shift_right_unit;
  import vshift_pkg::*;
  logic        i_mclk, i_rst_n, i_issue, o_valid, o_hit;
  logic [31:0] i_instr;
  logic [63:0] i_amount_source_reg, i_value_source_reg, o_result, rf_q, last_e;
  logic [4:0]  o_dest_idx;
  int          errors, total_checks;

  dsp_vector_shift_right_unit DUT (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_issue(i_issue), .i_instr(i_instr),
    .i_amount_source_reg(i_amount_source_reg),
    .i_value_source_reg(i_value_source_reg), .o_valid(o_valid),
    .o_hit(o_hit), .o_dest_idx(o_dest_idx), .o_result(o_result));
  wb_regfile wb (.i_mclk(i_mclk), .i_we(o_valid & o_hit),
    .i_wr_idx(o_dest_idx), .i_wr_data(o_result), .i_rd_idx(5'h03),
    .o_rd_data(rf_q));

  // ==========================================================
  // Reference arithmetic and shared drivers
  // ==========================================================
  function automatic logic [63:0] model(input logic [4:0] sub,
    input logic [4:0] amt, input logic [63:0] rs, input logic [63:0] rt);
    logic        [31:0] r;
    logic signed [8:0]  b;
    logic signed [32:0] w;
    r = 32'h0;
    for (int i = 0; i < 4; i++)
    begin
      b = $signed({rt[8*i +: 8], 1'b0}) >>> rs[2:0];
      b = b + 9'(sub == SUB_BQ_VAR_RND);
      r[8*i +: 8] = b[8:1];
    end
    w = $signed({rt[31:0], 1'b0}) >>> (sub == SUB_W_VAR_RND ? rs[4:0] : amt);
    w = w + 33'h1;
    if (sub == SUB_W_VAR_RND || sub == SUB_W_IMM_RND)
      r = w[32:1];
    if (sub == SUB_HP_IMM_LOG)
      r = {rt[31:16] >> amt[3:0], rt[15:0] >> amt[3:0]};
    return {{32{r[31]}}, r};
  endfunction

  task automatic check(input string n, input logic [63:0] s, e);
    total_checks++;
    if (s !== e)
    begin
      errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // Issues one instruction and leaves issue high so calls run back to back; the caller drops it
  task automatic issue(input logic [4:0] sub, amt, rd,
    input logic [63:0] rs, rt, input logic hit, input logic [5:0] fn = 6'h13);
    last_e = hit ? model(sub, amt, rs, rt) : 64'h0;
    i_issue = 1'b1;
    i_instr = {EXT_MAJOR_OPCODE, amt, 5'h01, rd, sub, fn};
    i_amount_source_reg = rs;
    i_value_source_reg = rt;
    @(posedge i_mclk);
    #1;
    check("valid", {63'h0, o_valid}, 64'h1);
    check("hit", {63'h0, o_hit}, {63'h0, hit});
    check("dest", {59'h0, o_dest_idx}, {59'h0, rd});
    check("result", o_result, last_e);
  endtask

  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_byte;
    for (int a = 0; a < 16; a++)
    begin
      issue(SUB_BQ_VAR, 5'h0, 5'h03, 64'hfff8 | a, 64'h807f_8103, 1);
      issue(SUB_BQ_VAR_RND, 5'h0, 5'h03, a, 64'h80ff_7f05, 1);
    end
    $display("byte shifts done");
  endtask

  task automatic t_word;
    for (int a = 0; a < 32; a++)
    begin
      issue(SUB_W_VAR_RND, 5'h0, 5'h03, 64'hffe0 | a, 64'h8000_0001, 1);
      issue(SUB_W_IMM_RND, 5'(a), 5'h03, 64'h0, 64'h7fff_ffff, 1);
    end
    $display("word shifts done");
  endtask

  task automatic t_half;
    for (int a = 0; a < 16; a++)
      issue(SUB_HP_IMM_LOG, 5'(a), 5'h03, 64'h0, 64'h8001_ffff, 1);
    i_issue = 1'b0;
    @(posedge i_mclk);
    #1;
    check("writeback", rf_q, last_e);
    check("idle result", o_result, 64'h0);
    $display("halfword shift done");
  endtask

  task automatic t_refuse;
    issue(SUB_HP_IMM_LOG, 5'h11, 5'h04, 64'h0, 64'h8001_ffff, 0);
    issue(5'h00, 5'h01, 5'h05, 64'h1, 64'h8000_0000, 0);
    issue(SUB_BQ_VAR, 5'h01, 5'h06, 64'h1, 64'h8000_0000, 0, 6'h12);
    i_issue = 1'b0;
    @(posedge i_mclk);
    #1;
    check("idle valid", {63'h0, o_valid}, 64'h0);
    check("quiet result", o_result, 64'h0);
    $display("refusals done");
  endtask

  // Mid-run reset drops a pending result at once; the first edge after
  // release already takes a new instruction
  task automatic t_reset;
    issue(SUB_W_IMM_RND, 5'h01, 5'h07, 64'h0, 64'h0000_0003, 1);
    i_rst_n = 1'b0;
    #1;
    check("reset valid", {63'h0, o_valid}, 64'h0);
    check("reset result", o_result, 64'h0);
    @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    issue(SUB_W_IMM_RND, 5'h01, 5'h07, 64'h0, 64'h0000_0003, 1);
    $display("reset done");
  endtask

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    i_mclk = 1'b0;
    forever #20 i_mclk = ~i_mclk;
  end

  // Watchdog: the whole run needs about 140 cycles
  initial
  begin
    #(40 * 2000);
    errors++;
    finish_test();
  end

  initial
  begin
    errors = 0;
    total_checks = 0;
    {i_rst_n, i_issue, i_instr} = '0;
    {i_amount_source_reg, i_value_source_reg} = '0;
    repeat (20) @(posedge i_mclk);
    #1;
    i_rst_n = 1'b1;
    t_byte();
    t_word();
    t_half();
    t_refuse();
    t_reset();
    finish_test();
  end
endmodule // tb_dsp_vector_shift_right_unit
`default_nettype wire
